/* File: tms_pkg.sv */
package tms_pkg;
    // Register offsets (byte addresses, four apart, on the plain register port)
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_RATIO  = 8'h04;
    localparam logic [7:0] OFS_THRESH = 8'h08;
    localparam logic [7:0] OFS_STAT   = 8'h0C;
    localparam logic [7:0] OFS_MASK   = 8'h10;
    localparam logic [7:0] OFS_RES0   = 8'h14;
    localparam logic [7:0] OFS_RES1   = 8'h18;
    localparam logic [7:0] OFS_RES2   = 8'h1C;
    localparam logic [7:0] OFS_PULSE  = 8'h20;

    // Control field positions
    localparam int CTRL_START   = 0;
    localparam int CTRL_GEN2    = 1;
    localparam int CTRL_MULTI   = 2;
    localparam int CTRL_VOTE    = 3;
    localparam int CTRL_HWJUDGE = 4;
    localparam int CTRL_IDLE_LO = 8;
    localparam int CTRL_PIN_LO  = 12;
    localparam int CTRL_REP_LO  = 16;

    // Reset values
    localparam logic [31:0] CTRL_RST   = 32'h0001_0000;
    localparam logic [31:0] RATIO_RST  = 32'h0000_0000;
    localparam logic [31:0] THRESH_RST = 32'h0000_0100;
    localparam logic [15:0] PULSE_RST  = 16'h0032;

    // Timing figures in drive-pulse periods (first generation)
    localparam int GEN1_MEAS_PERIODS   = 263;
    localparam int GEN1_SETTLE_PERIODS = 34;
    // Second generation count and times in microseconds and cycles; shared figures
    localparam int GEN2_REPEAT         = 8;
    localparam int GEN2_MEAS_US        = 128;
    localparam int GEN2_SETTLE_US      = 64;
    localparam int CLK_MHZ             = 200;
    localparam int GEN2_MEAS_CYC       = GEN2_MEAS_US * CLK_MHZ;
    localparam int GEN2_SETTLE_CYC     = GEN2_SETTLE_US * CLK_MHZ;
    localparam int NUM_FREQ            = 3;
    localparam int SYNC_STAGES         = 3;

    // Interrupt event bits
    localparam int EV_DONE  = 0;
    localparam int EV_TOUCH = 1;
    localparam int EV_OVF   = 2;

    typedef enum {ST_IDLE, ST_SETTLE, ST_MEAS, ST_JUDGE} tms_state_e;

    // Result record handed to the judge
    typedef struct packed {
        logic [15:0] cnt0;
        logic [15:0] cnt1;
        logic [15:0] cnt2;
    } tms_res_s;
endpackage

/* File: tms_edge_cnt.sv */
`timescale 1ns/10ps
// Oscillator edge counter with 3-stage pin synchroniser
module tms_edge_cnt (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Control
    input  wire logic        clr,
    input  wire logic        en,
    input  wire logic        osc_in,
    // Result
    output logic [15:0]      count_q,
    output logic             ovf_q
);
    logic [2:0] sync_q;     // Pin synchroniser chain
    logic       level_q;    // Accepted level

    // Synchroniser; first stage read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], osc_in};
        end
    end

    // Level accepted once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= 1'b0;
        end else if (sync_q[1] == sync_q[2]) begin
            level_q <= sync_q[2];
        end
    end

    // Count rising edges; saturate so a wrap never looks small
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 16'h0000;
            ovf_q   <= 1'b0;
        end else if (clr) begin
            count_q <= 16'h0000;
            ovf_q   <= 1'b0;
        end else if (en && !level_q && sync_q[1] == sync_q[2] && sync_q[2]) begin
            if (count_q == 16'hFFFF) begin
                ovf_q <= 1'b1;
            end else begin
                count_q <= count_q + 16'h0001;
            end
        end
    end
endmodule

/* File: tms_top.sv */
`timescale 1ns/10ps
// What this block does
// (R1) Measurement spans configurable charge/discharge repeat count
// (R2) Second generation forces repeat count eight
// (R3) Gen1 measure time 263 pulses times count
// (R4) Gen1 settle 34 pulse periods before measuring
// (R5) Software pairs frequency with repeat count
// (R6) Gen2 per-frequency measurement lasts 128 us
// (R7) Multi-clock measures at three configured ratios
// (R8) Value majority sums two closest results
// (R9) Vote majority judges each, takes majority
// (R10) Setting selects hardware or software judgment
// (R11) Oscillator correction follows hardware judgment
// (R12) Multi correction only value-majority plus hardware
// (R13) Idle pins driven by configured handling
// (R14) Low supply forces reduced reference voltage
// (R15) Software retunes offset target on count change
// (R16) Gen2 settle 64 us per frequency
// (R17) Software sets timing reference to 0.5 MHz
// (R18) Completion reports results and touch decision
module tms_top (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RSTN,
    // Register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [31:0]      RDATA,
    // Sensor side
    input  wire logic        OSC_IN,
    input  wire logic        LOW_SUPPLY,
    output logic [3:0]       PIN_SEL,
    output logic [1:0]       IDLE_PIN_MODE,
    output logic [7:0]       PULSE_RATIO,
    output logic             DRIVE_EN,
    output logic             LOW_VREF,
    output logic             OSC_CORR_HW,
    output logic             MULTI_CORR_HW,
    // Host side
    output logic             TOUCH,
    output logic             IRQ
);
    // Registers
    logic [31:0]              ctrl_q;       // Control register
    logic [31:0]              ratio_q;      // Three pulse ratios
    logic [31:0]              thresh_q;     // Touch threshold
    logic [15:0]              pulse_q;      // Cycles per drive pulse
    logic [2:0]               stat_q;       // Sticky events
    logic [2:0]               mask_q;       // Event mask

    // Sequencer
    tms_pkg::tms_state_e      state_q;      // Sequencer state
    logic [31:0]              timer_q;      // Phase cycle counter
    logic [1:0]               freq_q;       // Current frequency index
    tms_pkg::tms_res_s        res_q;        // Per-frequency results
    logic                     touch_q;      // Touch decision
    logic [2:0]               ev_d;         // Event pulses this cycle

    // Supply level
    logic [2:0]               lv_q;         // Low-voltage synchroniser
    logic                     low_q;        // Accepted low-supply level

    // Counter link
    logic [15:0]              cnt;          // Counter output
    logic                     cnt_ovf;      // Counter saturated
    logic                     cnt_clr;      // Counter clear

    // Derived values
    logic [3:0]               rep;          // Effective repeat count
    logic [31:0]              settle_cyc;   // Settle length
    logic [31:0]              meas_cyc;     // Measure length
    logic [1:0]               last_freq;    // Final frequency index
    logic                     judge_d;      // Combined decision
    logic                     hw_judge;     // Hardware judgment on

    // Gen2 forces eight, else the programmed count
    assign rep = ctrl_q[tms_pkg::CTRL_GEN2] ? 4'(tms_pkg::GEN2_REPEAT)    // see (R2)
                                          : ctrl_q[tms_pkg::CTRL_REP_LO +: 4];  // see (R1)

    // Judge place, frequency count
    assign hw_judge  = ctrl_q[tms_pkg::CTRL_HWJUDGE];   // see (R10)
    assign last_freq = ctrl_q[tms_pkg::CTRL_MULTI] ? 2'(tms_pkg::NUM_FREQ - 1) : 2'h0;  // see (R7)

    // Phase lengths in clock cycles
    always_comb begin
        if (ctrl_q[tms_pkg::CTRL_GEN2]) begin
            // Clock-cycle figures
            settle_cyc = 32'(tms_pkg::GEN2_SETTLE_CYC);  // see (R16)
            // Per-count time, so the forced count sets the length
            meas_cyc   = 32'(tms_pkg::GEN2_MEAS_CYC / tms_pkg::GEN2_REPEAT)
                         * {28'h0000000, rep};                                    // see (R6) (R2)
        end else begin
            // Scaled by pulse length
            settle_cyc = 32'(tms_pkg::GEN1_SETTLE_PERIODS) * {16'h0000, pulse_q};  // see (R4)
            meas_cyc   = 32'(tms_pkg::GEN1_MEAS_PERIODS) * {16'h0000, pulse_q}
                         * {28'h0000000, rep};                                    // see (R3)
        end
    end

    // Oscillator counter for the active frequency
    // Zeroed in every settle
    assign cnt_clr = (state_q == tms_pkg::ST_SETTLE);
    tms_edge_cnt u_cnt (
        .clk     (MCLK),
        .rst_n   (RSTN),
        .clr     (cnt_clr),
        .en      (state_q == tms_pkg::ST_MEAS),
        .osc_in  (OSC_IN),
        .count_q (cnt),
        .ovf_q   (cnt_ovf)
    );

    // Judgment: value majority or vote majority
    function automatic logic judge(input tms_pkg::tms_res_s r, input logic vote, input logic multi,
                                   input logic [31:0] th);
        logic [16:0] d01;
        logic [16:0] d12;
        logic [16:0] d02;
        logic [16:0] sum;
        logic [2:0]  v;

        // Pair spreads
        d01 = (r.cnt0 > r.cnt1) ? 17'(r.cnt0 - r.cnt1) : 17'(r.cnt1 - r.cnt0);
        d12 = (r.cnt1 > r.cnt2) ? 17'(r.cnt1 - r.cnt2) : 17'(r.cnt2 - r.cnt1);
        d02 = (r.cnt0 > r.cnt2) ? 17'(r.cnt0 - r.cnt2) : 17'(r.cnt2 - r.cnt0);
        // Votes per frequency
        v   = {r.cnt2 > th[15:0], r.cnt1 > th[15:0], r.cnt0 > th[15:0]};
        if (!multi) begin
            // Plain threshold test
            sum = {1'b0, r.cnt0};
            return v[0];
        end
        if (vote) begin
            // Two of three wins
            return (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);  // see (R9)
        end
        // Closest pair sum against doubled threshold
        // Ties go to the earlier pair
        if (d01 <= d12 && d01 <= d02) begin
            sum = 17'(r.cnt0) + 17'(r.cnt1);  // see (R8)
        end else if (d12 <= d02) begin
            sum = 17'(r.cnt1) + 17'(r.cnt2);
        end else begin
            sum = 17'(r.cnt0) + 17'(r.cnt2);
        end
        return sum > {th[15:0], 1'b0};
    endfunction

    // From latched results
    assign judge_d = judge(res_q, ctrl_q[tms_pkg::CTRL_VOTE], ctrl_q[tms_pkg::CTRL_MULTI], thresh_q);

    // Sequencer
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= tms_pkg::ST_IDLE;
            timer_q <= 32'h0000_0000;
            freq_q  <= 2'h0;
        end else begin
            case (state_q)
                tms_pkg::ST_IDLE: begin
                    // Start on a write of the start bit
                    if (WR && ADDR == tms_pkg::OFS_CTRL && WDATA[tms_pkg::CTRL_START]) begin
                        state_q <= tms_pkg::ST_SETTLE;
                        timer_q <= 32'h0000_0000;
                        freq_q  <= 2'h0;
                    end
                end

                tms_pkg::ST_SETTLE: begin
                    // Settle precedes every frequency
                    // Timer from zero: stop one short
                    if (timer_q + 32'h1 >= settle_cyc) begin  // see (R4)
                        state_q <= tms_pkg::ST_MEAS;
                        timer_q <= 32'h0000_0000;
                    end else begin
                        timer_q <= timer_q + 32'h1;
                    end
                end

                tms_pkg::ST_MEAS: begin
                    if (timer_q + 32'h1 >= meas_cyc) begin  // see (R1)
                        timer_q <= 32'h0000_0000;
                        if (freq_q == last_freq) begin
                            // Last frequency
                            state_q <= tms_pkg::ST_JUDGE;
                        end else begin
                            // Next frequency
                            freq_q  <= freq_q + 2'h1;  // see (R7)
                            state_q <= tms_pkg::ST_SETTLE;  // see (R16)
                        end
                    end else begin
                        timer_q <= timer_q + 32'h1;
                    end
                end

                tms_pkg::ST_JUDGE: begin
                    // One decision cycle
                    state_q <= tms_pkg::ST_IDLE;
                end

                default: begin
                    // Recover to idle
                    state_q <= tms_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Capture count at the end of each frequency's measurement
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            res_q <= '0;
        end else if (state_q == tms_pkg::ST_MEAS && timer_q + 32'h1 >= meas_cyc) begin
            // Before the next clear
            case (freq_q)
                2'h0:    res_q.cnt0 <= cnt;
                2'h1:    res_q.cnt1 <= cnt;
                default: res_q.cnt2 <= cnt;
            endcase
        end
    end

    // Touch decision only held when hardware judgment is on
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            touch_q <= 1'b0;
        end else if (state_q == tms_pkg::ST_JUDGE) begin
            // Low under software judging
            touch_q <= hw_judge & judge_d;  // see (R10) (R18)
        end
    end

    // Event pulses
    always_comb begin
        ev_d = 3'h0;
        ev_d[tms_pkg::EV_DONE]  = (state_q == tms_pkg::ST_JUDGE);  // see (R18)
        ev_d[tms_pkg::EV_TOUCH] = (state_q == tms_pkg::ST_JUDGE) && hw_judge && judge_d;
        // Only while measuring
        ev_d[tms_pkg::EV_OVF]   = (state_q == tms_pkg::ST_MEAS) && cnt_ovf;
    end

    // Configuration registers
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_q   <= tms_pkg::CTRL_RST;
            ratio_q  <= tms_pkg::RATIO_RST;
            thresh_q <= tms_pkg::THRESH_RST;
            pulse_q  <= tms_pkg::PULSE_RST;
            mask_q   <= 3'h0;
        end else if (WR) begin
            case (ADDR)
                tms_pkg::OFS_CTRL:   ctrl_q   <= {WDATA[31:1], 1'b0};  // Start is self-clearing
                tms_pkg::OFS_RATIO:  ratio_q  <= WDATA;
                tms_pkg::OFS_THRESH: thresh_q <= WDATA;
                // Zero would stall timing
                tms_pkg::OFS_PULSE:  pulse_q  <= (WDATA[15:0] == 16'h0000) ? 16'h0001 : WDATA[15:0];
                tms_pkg::OFS_MASK:   mask_q   <= WDATA[2:0];
                // Others ignore writes
                default: begin
                end
            endcase
        end
    end

    // Sticky status: a new event wins over write-one-to-clear
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            stat_q <= 3'h0;
        end else begin
            // Clear only on status writes
            stat_q <= (stat_q & ~((WR && ADDR == tms_pkg::OFS_STAT) ? WDATA[2:0] : 3'h0)) | ev_d;
        end
    end

    // Low-supply pin synchroniser, three stages
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            lv_q  <= 3'h0;
            low_q <= 1'b0;
        end else begin
            lv_q <= {lv_q[1:0], LOW_SUPPLY};
            // Hold while stages differ
            if (lv_q[1] == lv_q[2]) begin
                low_q <= lv_q[2];
            end
        end
    end

    // Read port: data the cycle after the strobe
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= 32'h0000_0000;
        end else if (RD) begin
            case (ADDR)
                // Start bit reads as busy
                tms_pkg::OFS_CTRL:   RDATA <= ctrl_q | {31'h0, state_q != tms_pkg::ST_IDLE};
                tms_pkg::OFS_RATIO:  RDATA <= ratio_q;
                tms_pkg::OFS_THRESH: RDATA <= thresh_q;
                tms_pkg::OFS_STAT:   RDATA <= {29'h0, stat_q};
                tms_pkg::OFS_MASK:   RDATA <= {29'h0, mask_q};
                // Read-only results
                tms_pkg::OFS_RES0:   RDATA <= {16'h0, res_q.cnt0};  // see (R18)
                tms_pkg::OFS_RES1:   RDATA <= {16'h0, res_q.cnt1};
                tms_pkg::OFS_RES2:   RDATA <= {16'h0, res_q.cnt2};
                tms_pkg::OFS_PULSE:  RDATA <= {16'h0, pulse_q};
                default:             RDATA <= 32'h0000_0000;
            endcase
        end else begin
            // Idle bus reads zero
            RDATA <= 32'h0000_0000;
        end
    end

    // Registered sensor-side and host-side outputs
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            PIN_SEL       <= 4'h0;
            IDLE_PIN_MODE <= 2'h0;
            PULSE_RATIO   <= 8'h00;
            DRIVE_EN      <= 1'b0;
            LOW_VREF      <= 1'b0;
            OSC_CORR_HW   <= 1'b0;
            MULTI_CORR_HW <= 1'b0;
            TOUCH         <= 1'b0;
            IRQ           <= 1'b0;
        end else begin
            // Configuration mirrors
            PIN_SEL       <= ctrl_q[tms_pkg::CTRL_PIN_LO +: 4];
            IDLE_PIN_MODE <= ctrl_q[tms_pkg::CTRL_IDLE_LO +: 2];  // see (R13)
            PULSE_RATIO   <= ratio_q[8 * freq_q +: 8];            // see (R7)
            // Settle plus measure
            DRIVE_EN      <= (state_q == tms_pkg::ST_SETTLE) || (state_q == tms_pkg::ST_MEAS);
            LOW_VREF      <= low_q;                               // see (R14)
            OSC_CORR_HW   <= hw_judge;                            // see (R11)
            MULTI_CORR_HW <= hw_judge && !ctrl_q[tms_pkg::CTRL_VOTE];  // see (R12)
            TOUCH         <= touch_q;
            // Unmasked status level
            IRQ           <= |(stat_q & mask_q);
        end
    end
endmodule

/* File: tms_top_asserts.sv */
`timescale 1ns/10ps
// Port-level checks on the touch sequencer
module tms_chk (
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        RSTN,
    // Register port
    input wire logic [7:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    // Sensor and host side
    input wire logic        LOW_SUPPLY,
    input wire logic [3:0]  PIN_SEL,
    input wire logic [1:0]  IDLE_PIN_MODE,
    input wire logic        DRIVE_EN,
    input wire logic        LOW_VREF,
    input wire logic        OSC_CORR_HW,
    input wire logic        MULTI_CORR_HW,
    input wire logic        TOUCH
);
    // One clock domain, so one default clock and reset
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    // Control write taken while idle
    sequence s_ctrl_wr;
        WR && ADDR == tms_pkg::OFS_CTRL && !DRIVE_EN;
    endsequence
    // Control write that also requests a run
    sequence s_start;
        s_ctrl_wr ##0 WDATA[tms_pkg::CTRL_START];
    endsequence
    property p_osc_corr;
        s_ctrl_wr |-> ##2 OSC_CORR_HW == $past(WDATA[tms_pkg::CTRL_HWJUDGE], 2);
    endproperty
    a_osc_corr: assert property (p_osc_corr) else $error("oscillator correction not following judge");
    property p_multi_corr;
        s_ctrl_wr |-> ##2 MULTI_CORR_HW ==
            ($past(WDATA[tms_pkg::CTRL_HWJUDGE], 2) && !$past(WDATA[tms_pkg::CTRL_VOTE], 2));
    endproperty
    a_multi_corr: assert property (p_multi_corr) else $error("multi correction selection wrong");
    property p_corr_dep;
        MULTI_CORR_HW |-> OSC_CORR_HW;
    endproperty
    a_corr_dep: assert property (p_corr_dep) else $error("multi correction without hardware judge");
    property p_start;
        s_start |-> ##[1:3] DRIVE_EN;
    endproperty
    a_start: assert property (p_start) else $error("run did not start");
    property p_drive_min;
        $rose(DRIVE_EN) |-> DRIVE_EN [*8];
    endproperty
    a_drive_min: assert property (p_drive_min) else $error("drive interval too short");
    property p_touch_hold;
        $changed(TOUCH) |-> !DRIVE_EN;
    endproperty
    a_touch_hold: assert property (p_touch_hold) else $error("decision changed mid measurement");
    property p_pins_stable;
        DRIVE_EN && $past(DRIVE_EN) |-> $stable(PIN_SEL) && $stable(IDLE_PIN_MODE);
    endproperty
    a_pins_stable: assert property (p_pins_stable) else $error("pin handling moved while driving");
    property p_vref_on;
        LOW_SUPPLY [*6] |-> LOW_VREF;
    endproperty
    a_vref_on: assert property (p_vref_on) else $error("low supply without reduced reference");
    property p_vref_off;
        !LOW_SUPPLY [*6] |-> !LOW_VREF;
    endproperty
    a_vref_off: assert property (p_vref_off) else $error("reduced reference without low supply");
    property p_rdata_slot;
        RDATA != 32'h0000_0000 |-> $past(RD) && !$past(ADDR == 8'hFC);
    endproperty
    a_rdata_slot: assert property (p_rdata_slot) else $error("read data outside its slot");
endmodule

/* File: tms_osc_model.sv */
`timescale 1ns/10ps
// Electrode oscillator: fast when touched, still when not driven
module tms_osc_model (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // From the sequencer
    input wire logic       drive_en,
    input wire logic [7:0] ratio,
    // Bench control: which ratio index sees a finger
    input wire logic [3:0] fast_set,
    // To the sequencer
    output logic           osc
);
    logic [2:0] div_q; // Half-period counter
    logic       fast;  // Touched at the current frequency
    assign fast = fast_set[ratio[5:4]];
    // Period 4 when touched, 16 when not; no edges between runs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 3'h0;
            osc   <= 1'b0;
        end else if (!drive_en) begin
            div_q <= 3'h0;
        end else if (div_q == (fast ? 3'h1 : 3'h7)) begin
            div_q <= 3'h0;
            osc   <= !osc;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end
endmodule

/* File: testbench.sv */
`timescale 1ns/10ps
// Self-checking bench for the touch sequencer
module testbench;
    logic        mclk = 1'b0;       // 200 MHz clock
    logic        rstn = 1'b0;       // Active low reset
    logic [7:0]  addr = 8'h00;      // Register address
    logic [31:0] wdata = 32'h0;     // Write data
    logic        wr = 1'b0;         // Write strobe
    logic        rd = 1'b0;         // Read strobe
    logic        low_supply = 1'b0; // Supply below threshold
    logic [3:0]  fast_set = 4'h0;   // Touched ratio indices
    logic [31:0] rdata;
    logic        osc, drive_en, low_vref, osc_corr, multi_corr, touch, irq;
    logic [3:0]  pin_sel, pin_seen, seen;
    logic [1:0]  idle_mode, idle_seen;
    logic [7:0]  ratio;
    int          failures = 0;
    int          comparisons = 0;
    int          drv_cnt = 0;       // Cycles with drive on
    always #2.5 mclk = ~mclk;
    tms_top dut (.MCLK(mclk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .OSC_IN(osc), .LOW_SUPPLY(low_supply), .PIN_SEL(pin_sel), .IDLE_PIN_MODE(idle_mode),
        .PULSE_RATIO(ratio), .DRIVE_EN(drive_en), .LOW_VREF(low_vref), .OSC_CORR_HW(osc_corr),
        .MULTI_CORR_HW(multi_corr), .TOUCH(touch), .IRQ(irq));
    tms_osc_model u_osc (.clk(mclk), .rst_n(rstn), .drive_en(drive_en), .ratio(ratio),
        .fast_set(fast_set), .osc(osc));
    // Drive time, ratios and pin handling seen during a run
    always @(posedge mclk) begin
        if (drive_en === 1'b1) begin
            drv_cnt <= drv_cnt + 1;
            seen[ratio[5:4]] <= 1'b1;
            pin_seen <= pin_sel;
            idle_seen <= idle_mode;
        end
    end
    task automatic wrap_up();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 check(rdata & m, exp);
    endtask
    // Interrupt output is registered behind the status and mask
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge mclk);
        #1 check(irq, exp);
    endtask
    // One run: start, busy flag, drive time, decision, interrupt handling
    task automatic run(input logic [31:0] ctrl, input int exp, input logic exp_touch, input logic [3:0] exp_seen);
        int n;
        drv_cnt = 0;
        seen = 4'h0;
        wr_reg(tms_pkg::OFS_CTRL, ctrl | 32'h1);
        rd_chk(tms_pkg::OFS_CTRL, 32'h1, 32'h1);
        for (n = 0; n < 2 * exp + 200 && irq !== 1'b1; n++)
            @(posedge mclk);
        if (irq !== 1'b1) begin
            failures++;
            $display("BAD %0t run never finished", $time);
            wrap_up();
        end
        check(drv_cnt >= exp - 12 && drv_cnt <= exp + 12, 1'b1);
        check(touch, exp_touch);
        check(seen, exp_seen);
        rd_chk(tms_pkg::OFS_STAT, 32'h1, 32'h1);
        wr_reg(tms_pkg::OFS_MASK, 32'h0);
        irq_chk(1'b0);
        wr_reg(tms_pkg::OFS_MASK, 32'h1);
        irq_chk(1'b1);
        wr_reg(tms_pkg::OFS_STAT, 32'h7);
        irq_chk(1'b0);
        rd_chk(tms_pkg::OFS_STAT, 32'h1, 32'h0);
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        // Reset values, then an unmapped address
        rd_chk(tms_pkg::OFS_CTRL, 32'hFFFF_FFFF, tms_pkg::CTRL_RST);
        rd_chk(tms_pkg::OFS_RATIO, 32'hFFFF_FFFF, tms_pkg::RATIO_RST);
        rd_chk(tms_pkg::OFS_THRESH, 32'hFFFF_FFFF, tms_pkg::THRESH_RST);
        rd_chk(tms_pkg::OFS_PULSE, 32'hFFFF_FFFF, {16'h0000, tms_pkg::PULSE_RST});
        rd_chk(tms_pkg::OFS_STAT, 32'hFFFF_FFFF, 32'h0);
        rd_chk(8'hFC, 32'hFFFF_FFFF, 32'h0);
        // Reduced reference tracks the supply level both ways
        for (int v = 1; v >= 0; v--) begin
            @(posedge mclk) low_supply <= v[0];
            repeat (8) @(posedge mclk);
            #1 check(low_vref, v[0]);
        end
        // One clock per drive pulse keeps runs short
        wr_reg(tms_pkg::OFS_PULSE, 32'h1);
        wr_reg(tms_pkg::OFS_RATIO, 32'h0030_2010);
        wr_reg(tms_pkg::OFS_MASK, 32'h1);
        wr_reg(tms_pkg::OFS_THRESH, 32'h30);
        @(posedge mclk) fast_set <= 4'hE;
        run(32'h0001_5210, 297, 1'b1, 4'h2);
        check(pin_seen, 4'h5);
        check(idle_seen, 2'h2);
        check(osc_corr, 1'b1);
        check(multi_corr, 1'b1);
        // About 65 fast edges in 263 cycles
        rd_chk(tms_pkg::OFS_RES0, 32'hFFFF_FFC0, 32'h40);
        // Doubled count doubles counts, so the target moves with it
        wr_reg(tms_pkg::OFS_THRESH, 32'h60);
        @(posedge mclk) fast_set <= 4'h0;
        run(32'h0002_0010, 560, 1'b0, 4'h2);
        // Half the pulse rate with half the count keeps the measure time
        wr_reg(tms_pkg::OFS_PULSE, 32'h2);
        run(32'h0001_0010, 594, 1'b0, 4'h2);
        wr_reg(tms_pkg::OFS_PULSE, 32'h1);
        wr_reg(tms_pkg::OFS_THRESH, 32'h30);
        @(posedge mclk) fast_set <= 4'hE;
        // Software judgement raises no hardware touch
        run(32'h0001_0000, 297, 1'b0, 4'h2);
        check(osc_corr, 1'b0);
        check(multi_corr, 1'b0);
        // Three ratios, both judge modes, two or one touched
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk) fast_set <= i[0] ? 4'h8 : 4'h6;
            run(32'h0001_0014 | {28'h0, i[1], 3'h0}, 891, !i[0], 4'hE);
            check(multi_corr, !i[1]);
        end
        @(posedge mclk) fast_set <= 4'hE;
        // Fixed times assume the recommended reference; count 3 is overridden
        run(32'h0003_0012, 38400, 1'b1, 4'h2);
        wrap_up();
    end
endmodule
bind tms_top tms_chk u_chk (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .LOW_SUPPLY(LOW_SUPPLY), .PIN_SEL(PIN_SEL), .IDLE_PIN_MODE(IDLE_PIN_MODE),
    .DRIVE_EN(DRIVE_EN), .LOW_VREF(LOW_VREF), .OSC_CORR_HW(OSC_CORR_HW), .MULTI_CORR_HW(MULTI_CORR_HW),
    .TOUCH(TOUCH));
